// *** rtl/clr_line_receiver.sv ***
// Receive side of the single-wire control bus with its register slave.
// Overview of operation
// (RULE_01) Line sampled by divided 32.768kHz tick or by the timer output.
// (RULE_02) Valid start bit sets the start flag; interrupt only if enabled.
// (RULE_03) Completed block is buffered, flagged and raises receive interrupt.
// (RULE_04) Buffer holds data, EOM and ACK; ACK is the observed level.
// (RULE_05) Blocks continue until one with EOM set; then wait for start.
// (RULE_06) Errors interrupt, discard the block and wait for a start bit.
// (RULE_07) Address mask: one bit per own logical address.
// (RULE_08) Broadcast always received; ACK only when address 15 enabled.
// (RULE_09) Level changes accepted after a set run of equal samples.
// (RULE_10) High code 10 needs three samples, low code 011 needs four.
// (RULE_11) Software sets the low filter like the transmitter detector.
// (RULE_12) Fall-to-fall period checked against 67/fs and 90/fs, trimmed.
// (RULE_13) Bit decided at 34/fs plus trim from -8 to +6 in steps of two.
// (RULE_14) Header match always ACKs; data match ACKs unless disabled.
// (RULE_15) ACK drives line low for about 1.526 ms from the filtered fall.
// (RULE_16) Suspended errors answer with inverted ACK, then interrupt.
// (RULE_17) Suspended errors time out when bits stop, then interrupt.
// (RULE_18) Foreign messages may be received but are never acknowledged.
// (RULE_19) Start bit before EOM gives a maximum cycle error, then receives.
// (RULE_20) Start bit needs rise and next fall inside programmed windows.
// (RULE_21) Waveform check flags early, mid-gap and missing rising edges.
// (RULE_22) Reception needs the enable; clearing it stops and discards.
// (RULE_23) Minimum cycle error drives the line low for about 3.63 ms.
// (RULE_24) Line input is synchronised before noise filtering.
`timescale 1ns/1ps
`default_nettype none
module clr_line_receiver import clr_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic cec_in,
  input wire logic timer_out_clock,
  output logic cec_out,
  output logic cec_oe,
  output logic irq_start,
  output logic irq_rx,
  output logic irq_err
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic ready;
    logic [31:0] rdata;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [6:0] ctrl;
    logic [15:0] amask;
    logic [31:0] tim;
    logic [31:0] swav;
    logic [31:0] wav;
    logic [7:0] status;
    logic [9:0] rbuf;
    logic full;
    clr_state_t state;
    logic [7:0] cnt;
    logic [7:0] drv;
    logic [3:0] bitn;
    logic [8:0] shreg;
    logic header;
    logic matched;
    logic ack_drv;
    logic rose_seen;
    logic [2:0] pend;
    logic oe;
    logic irq_s;
    logic irq_r;
    logic irq_e;
  } clr_rx_t;
  clr_rx_t r;
  clr_rx_t next_r;
  logic tick;
  logic stb;
  logic lo;
  logic fell;
  logic rose;
  clr_sample_tick u_tick (
    .clk(clk),
    .rst_n(rst_n),
    .sample_clock_choice(r.ctrl[C_CLKSEL]), // RULE_01
    .timer_out_clock(timer_out_clock),
    .tick(tick)
  );
  clr_line_filter u_filt (
    .clk(clk),
    .rst_n(rst_n),
    .tick(tick),
    .line_in(cec_in),
    .high_code(r.tim[T_HNC +: 2]),
    .low_code(r.tim[T_LNC +: 3]),
    .line_low(lo),
    .fell(fell),
    .rose(rose),
    .stb(stb)
  );
  function automatic logic [7:0] trim(input logic [7:0] b,
                                      input logic [2:0] a);
    trim = b + {{5{a[2]}}, a};
  endfunction
  logic [7:0] min_lim;
  logic [7:0] max_lim;
  logic [7:0] dec_pt;
  logic [7:0] cnt_n;
  logic [3:0] dest;
  logic [2:0] err;
  logic hold;
  always_comb begin
    min_lim = trim(CYC_MIN_BASE, r.tim[T_MIN +: 3]); // RULE_12
    max_lim = trim(CYC_MAX_BASE, r.tim[T_MAX +: 3]);
    dec_pt = DECIDE_BASE + {{4{r.tim[T_DAT + 2]}}, r.tim[T_DAT +: 3], 1'b0};
    cnt_n = (r.cnt == 8'hff) ? r.cnt : r.cnt + 8'h01;
    dest = r.shreg[3:0];
    hold = r.ctrl[C_HOLD];
    err = 3'b000;
    next_r = r;
    next_r.irq_s = 1'b0;
    next_r.irq_r = 1'b0;
    next_r.irq_e = 1'b0;
    // -------------------------------------------------------------
    // Bus slave: writes land in the data phase, reads are prepared
    // in the address phase so read data come straight from a flop.
    // -------------------------------------------------------------
    next_r.ready = 1'b1;
    next_r.wr_pend = 1'b0;
    if (r.wr_pend) begin
      unique case (r.wr_addr)
        A_CTRL: next_r.ctrl = hwdata[6:0];
        A_ADDR: next_r.amask = hwdata[15:0]; // RULE_07
        A_TIME: next_r.tim = hwdata;
        A_START: next_r.swav = hwdata;
        A_WAVE: next_r.wav = hwdata;
        A_STAT: next_r.status = r.status & ~hwdata[7:0];
        default: next_r.status = next_r.status;
      endcase
    end
    if (hsel && hready && htrans[1]) begin
      next_r.wr_pend = hwrite;
      next_r.wr_addr = {haddr[7:2], 2'b00};
      next_r.rdata = 32'h00000000;
      if (!hwrite) begin
        unique case ({haddr[7:2], 2'b00})
          A_CTRL: next_r.rdata = {25'h0000000, r.ctrl};
          A_ADDR: next_r.rdata = {16'h0000, r.amask};
          A_TIME: next_r.rdata = r.tim;
          A_START: next_r.rdata = r.swav;
          A_WAVE: next_r.rdata = r.wav;
          A_STAT: next_r.rdata = {23'h000000,
                                  r.state != ST_IDLE, r.status};
          A_BUF: begin
            next_r.rdata = {22'h000000, r.rbuf};
            next_r.full = 1'b0;
          end
          default: next_r.rdata = 32'h00000000;
        endcase
      end
    end
    // -------------------------------------------------------------
    // Receiver, advanced once per sampling tick
    // -------------------------------------------------------------
    if (stb) begin
      next_r.cnt = fell ? 8'h00 : cnt_n;
      if (r.drv != 8'h00) begin
        next_r.drv = r.drv - 8'h01;
      end
      next_r.oe = (next_r.drv != 8'h00);
      unique case (r.state)
        ST_IDLE: begin
          if (fell) begin
            next_r.state = ST_START_LOW;
          end
        end
        ST_START_LOW: begin
          if (rose) begin
            if (r.cnt >= r.swav[7:0] && r.cnt <= r.swav[15:8]) begin
              next_r.state = ST_START_HIGH; // RULE_20
            end else begin
              next_r.state = ST_IDLE;
            end
          end else if (r.cnt > r.swav[15:8]) begin
            next_r.state = ST_IDLE;
          end
        end
        ST_START_HIGH: begin
          if (fell) begin
            if (r.cnt >= r.swav[23:16] && r.cnt <= r.swav[31:24]) begin
              next_r.status[S_START] = 1'b1; // RULE_02
              next_r.irq_s = r.ctrl[C_STAIE];
              next_r.state = ST_BIT;
              next_r.bitn = 4'h0;
              next_r.header = 1'b1;
              next_r.rose_seen = 1'b0;
              next_r.pend = 3'b000;
            end else begin
              next_r.state = ST_IDLE;
            end
          end else if (r.cnt > r.swav[31:24]) begin
            next_r.state = ST_IDLE;
          end
        end
        ST_BIT: begin
          if (fell && r.cnt < min_lim) begin
            next_r.status[S_MIN] = 1'b1; // RULE_12
            next_r.status[S_MAX] |= r.pend[0];
            next_r.status[S_OVR] |= r.pend[1];
            next_r.status[S_WAV] |= r.pend[2];
            next_r.irq_e = 1'b1;
            next_r.state = ST_DRIVE; // RULE_23
            next_r.drv = 8'(MIN_ERR_TICKS);
            next_r.oe = 1'b1;
          end else if (fell) begin
            next_r.rose_seen = 1'b0;
            if (r.bitn == BLOCK_DONE) begin
              next_r.bitn = 4'h0;
            end
            if (r.bitn == ACK_BIT && (r.ack_drv ^ (r.pend != 3'b000))) begin
              next_r.drv = 8'(ACK_LOW_TICKS); // RULE_15 RULE_16
              next_r.oe = 1'b1;
            end
          end else begin
            if (cnt_n > max_lim) begin
              err[0] = 1'b1; // RULE_12 RULE_19
            end
            if (r.ctrl[C_WAVEN] && r.bitn != BLOCK_DONE) begin
              if (rose && (r.cnt < r.wav[7:0] || // RULE_21
                  (r.cnt > r.wav[15:8] && r.cnt < r.wav[23:16]))) begin
                err[2] = 1'b1;
              end
              if (lo && !r.rose_seen && r.cnt == r.wav[31:24]) begin
                err[2] = 1'b1;
              end
            end
            if (rose) begin
              next_r.rose_seen = 1'b1;
            end
            if (r.cnt == dec_pt && r.bitn != BLOCK_DONE) begin
              next_r.bitn = r.bitn + 4'h1; // RULE_13
              if (r.bitn != ACK_BIT) begin
                next_r.shreg = {r.shreg[7:0], ~lo};
              end
              if (r.bitn == EOM_BIT && r.header) begin
                next_r.matched = r.amask[dest]; // RULE_07
                next_r.ack_drv = r.amask[dest]; // RULE_08 RULE_14
                if (!r.amask[dest] && dest != BCAST_ADDR &&
                    !r.ctrl[C_OTHER]) begin // RULE_18
                  next_r.state = ST_IDLE;
                end
              end else if (r.bitn == EOM_BIT) begin
                next_r.ack_drv = r.matched & ~r.ctrl[C_ACKDIS]; // RULE_14
              end
              if (r.bitn == ACK_BIT) begin
                next_r.header = 1'b0;
                err[1] = r.full;
                if (!(r.full && !hold)) begin
                  next_r.rbuf = {~lo, r.shreg[0], // RULE_03 RULE_04
                                 r.shreg[8:1]};
                  next_r.full = 1'b1;
                  next_r.status[S_END] = 1'b1;
                  next_r.irq_r = 1'b1;
                  next_r.status[S_MAX] |= r.pend[0];
                  next_r.status[S_OVR] |= r.pend[1] | r.full;
                  next_r.status[S_WAV] |= r.pend[2];
                  next_r.irq_e = (r.pend != 3'b000) | r.full; // RULE_16
                  next_r.pend = 3'b000;
                  err[1] = 1'b0;
                  if (r.shreg[0]) begin
                    next_r.state = ST_IDLE; // RULE_05
                  end
                end
              end
            end
            if (err != 3'b000 && hold) begin
              next_r.pend = r.pend | err; // RULE_16
            end else if (err != 3'b000) begin
              next_r.status[S_MAX] |= err[0]; // RULE_06
              next_r.status[S_OVR] |= err[1];
              next_r.status[S_WAV] |= err[2];
              next_r.irq_e = 1'b1;
              next_r.state = lo ? ST_START_LOW : ST_IDLE; // RULE_19
            end
            if (hold && (r.pend | err) != 3'b000 &&
                cnt_n > r.tim[T_TOUT +: 8]) begin
              next_r.status[S_MAX] |= r.pend[0] | err[0];
              next_r.status[S_OVR] |= r.pend[1] | err[1];
              next_r.status[S_WAV] |= r.pend[2] | err[2];
              next_r.irq_e = 1'b1; // RULE_17
              next_r.pend = 3'b000;
              next_r.state = lo ? ST_START_LOW : ST_IDLE;
            end
          end
        end
        ST_DRIVE: begin
          if (r.drv == 8'h01) begin
            next_r.state = ST_IDLE;
          end
        end
        default: next_r.state = ST_IDLE;
      endcase
    end
    // Disabling reception also stops any low drive in progress.
    if (!r.ctrl[C_EN]) begin
      next_r.state = ST_IDLE; // RULE_22
      next_r.drv = 8'h00;
      next_r.oe = 1'b0;
      next_r.pend = 3'b000;
    end
  end
  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r <= '0;
      r.ready <= 1'b1;
      r.ctrl <= CTRL_RST;
      r.tim <= TIME_RST;
      r.swav <= START_RST;
      r.wav <= WAVE_RST;
    end else begin
      r <= next_r;
    end
  end
  assign hreadyout = r.ready;
  assign hresp = r.header & 1'b0;
  assign hrdata = r.rdata;
  assign cec_out = 1'b0;
  assign cec_oe = r.oe;
  assign irq_start = r.irq_s;
  assign irq_rx = r.irq_r;
  assign irq_err = r.irq_e;
endmodule
`default_nettype wire

// *** rtl/clr_pkg.sv ***
// Shared constants and types for the line receiver.
package clr_pkg;
  // ---------------------------------------------------------------
  // Clock rates and line timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 25000000;
  localparam int FS_HZ = 32768;
  localparam int FS_DIV = CLK_HZ / FS_HZ;
  localparam int ACK_LOW_US = 1526;
  localparam int ACK_LOW_TICKS = ACK_LOW_US * FS_HZ / 1000000;
  localparam int MIN_ERR_LOW_US = 3630;
  localparam int MIN_ERR_TICKS = MIN_ERR_LOW_US * FS_HZ / 1000000;
  localparam logic [7:0] CYC_MIN_BASE = 8'h43;
  localparam logic [7:0] CYC_MAX_BASE = 8'h5a;
  localparam logic [7:0] DECIDE_BASE = 8'h22;
  localparam logic [3:0] BCAST_ADDR = 4'hf;
  localparam logic [3:0] EOM_BIT = 4'h8;
  localparam logic [3:0] ACK_BIT = 4'h9;
  localparam logic [3:0] BLOCK_DONE = 4'ha;
  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_ADDR = 8'h04;
  localparam logic [7:0] A_TIME = 8'h08;
  localparam logic [7:0] A_START = 8'h0c;
  localparam logic [7:0] A_WAVE = 8'h10;
  localparam logic [7:0] A_STAT = 8'h14;
  localparam logic [7:0] A_BUF = 8'h18;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int C_EN = 0;
  localparam int C_CLKSEL = 1;
  localparam int C_STAIE = 2;
  localparam int C_ACKDIS = 3;
  localparam int C_OTHER = 4;
  localparam int C_HOLD = 5;
  localparam int C_WAVEN = 6;
  localparam int T_HNC = 0;
  localparam int T_LNC = 2;
  localparam int T_MIN = 8;
  localparam int T_MAX = 12;
  localparam int T_DAT = 16;
  localparam int T_TOUT = 24;
  localparam int S_END = 0;
  localparam int S_START = 1;
  localparam int S_MAX = 2;
  localparam int S_MIN = 3;
  localparam int S_OVR = 5;
  localparam int S_WAV = 6;
  localparam int S_BUSY = 8;
  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [6:0] CTRL_RST = 7'h00;
  localparam logic [31:0] TIME_RST = 32'hc8000000;
  localparam logic [31:0] START_RST = 32'h9a8c7f72;
  localparam logic [31:0] WAVE_RST = 32'h382a1a0d;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_START_LOW = 3'b001,
    ST_START_HIGH = 3'b011,
    ST_BIT = 3'b010,
    ST_DRIVE = 3'b110
  } clr_state_t;
endpackage

// *** rtl/clr_sample_tick.sv ***
// Sampling tick from the divided system clock or the timer output.
`timescale 1ns/1ps
`default_nettype none
module clr_sample_tick import clr_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sample_clock_choice,
  input wire logic timer_out_clock,
  output logic tick
);
  typedef struct packed {
    logic [9:0] cnt;
    logic s1;
    logic s2;
    logic s3;
    logic tick;
  } clr_tick_t;
  clr_tick_t r;
  clr_tick_t next_r;
  always_comb begin
    next_r = r;
    next_r.s1 = timer_out_clock;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    if (r.cnt == 10'(FS_DIV - 1)) begin
      next_r.cnt = 10'h000;
    end else begin
      next_r.cnt = r.cnt + 10'h001;
    end
    if (sample_clock_choice) begin
      next_r.tick = r.s2 & ~r.s3;
    end else begin
      next_r.tick = (r.cnt == 10'(FS_DIV - 1));
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
  assign tick = r.tick;
endmodule
`default_nettype wire

// *** rtl/clr_line_filter.sv ***
// Line synchroniser on the system clock and noise filter running on the sampling tick.
`timescale 1ns/1ps
`default_nettype none
module clr_line_filter import clr_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic line_in,
  input wire logic [1:0] high_code,
  input wire logic [2:0] low_code,
  output logic line_low,
  output logic fell,
  output logic rose,
  output logic stb
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic low;
    logic [3:0] run;
    logic fell;
    logic rose;
    logic stb;
  } clr_flt_t;
  clr_flt_t r;
  clr_flt_t next_r;
  logic [3:0] need;
  always_comb begin
    next_r = r;
    next_r.s1 = line_in;
    next_r.s2 = r.s1;
    next_r.fell = 1'b0;
    next_r.rose = 1'b0;
    next_r.stb = tick;
    need = r.s2 ? {2'b00, high_code} + 4'h1 : {1'b0, low_code} + 4'h1;
    if (tick) begin
      if (~r.s2 == r.low) begin
        next_r.run = 4'h0;
      end else if (r.run + 4'h1 >= need) begin
        next_r.low = ~r.s2; // RULE_09 RULE_10
        next_r.run = 4'h0;
        next_r.fell = ~r.s2;
        next_r.rose = r.s2;
      end else begin
        next_r.run = r.run + 4'h1;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= next_r; // RULE_24
    end
  end
  assign line_low = r.low;
  assign fell = r.fell;
  assign rose = r.rose;
  assign stb = r.stb;
endmodule
`default_nettype wire

// *** sim/clr_sva.sv ***
// Port checker for the line receiver, bound to its top module.
`timescale 1ns/1ps
`default_nettype none
module clr_sva import clr_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic timer_out_clock,
  input wire logic cec_out,
  input wire logic cec_oe,
  input wire logic irq_start,
  input wire logic irq_rx,
  input wire logic irq_err
);
  // ------------------------------------------
  // Shadow of the control word and drive timer
  // ------------------------------------------
  logic [6:0] ctrl;
  logic wr_c;
  logic tq;
  logic [1:0] off;
  logic [7:0] oe_len;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl <= CTRL_RST;
      wr_c <= 1'h0;
      tq <= 1'h0;
      off <= 2'h0;
      oe_len <= 8'h0;
    end else begin
      wr_c <= hsel && hready && htrans[1] && hwrite &&
        haddr[7:2] == A_CTRL[7:2];
      if (wr_c) begin
        ctrl <= hwdata[6:0];
      end
      tq <= timer_out_clock;
      off <= ctrl[C_EN] ? 2'h0 : (off == 2'h3 ? off : off + 2'h1);
      // Timer edges are counted raw, so a tolerance of two is allowed.
      oe_len <= !cec_oe ? 8'h0 :
        oe_len + {7'h0, timer_out_clock && !tq};
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_rd;
    hsel && hready && htrans[1] && !hwrite;
  endsequence
  property p_pulse(x);
    x |=> !x;
  endproperty
  a_fixed_outs: assert property (hresp == 1'h0 && hreadyout && !cec_out)
    else $error("bus response or line value not fixed");
  a_rx_pulse: assert property (p_pulse(irq_rx))
    else $error("receive interrupt longer than one cycle");
  a_err_pulse: assert property (p_pulse(irq_err))
    else $error("error interrupt longer than one cycle");
  a_start_gated: assert property (irq_start |-> ctrl[C_STAIE])
    else $error("start interrupt while not enabled");
  a_off_quiet: assert property (off == 2'h3 |->
    !cec_oe && !irq_rx && !irq_start)
    else $error("activity while reception disabled");
  a_drive_len: assert property ($fell(cec_oe) &&
    ctrl[C_EN] && ctrl[C_CLKSEL] |->
    oe_len inside {[8'h30:8'h34], [8'h74:8'h78]})
    else $error("line low drive of wrong length");
  a_rd_unmap: assert property (s_rd ##0 (haddr[7:2] > A_BUF[7:2])
    |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_ctrl_back: assert property (s_rd ##0 (haddr[7:2] == A_CTRL[7:2])
    |=> hrdata == {25'h0, $past(ctrl)})
    else $error("control read back differs");
endmodule
bind clr_line_receiver clr_sva u_sva (.clk(clk), .rst_n(rst_n),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .timer_out_clock(timer_out_clock), .cec_out(cec_out),
  .cec_oe(cec_oe), .irq_start(irq_start), .irq_rx(irq_rx),
  .irq_err(irq_err));
`default_nettype wire

// *** sim/clr_remote.sv ***
// Behavioural remote initiator on the shared control line.
`timescale 1ns/1ps
`default_nettype none
module clr_remote (
  input wire logic tclk,
  input wire logic line,
  output logic pull_low
);
  // A nonzero value bends the low time of the next block's first bit.
  int bad = 0;
  initial pull_low = 1'h0;
  task automatic pulse(input int low, input int per, output logic seen);
    for (int i = 0; i < per; i++) begin
      if (i == 0) begin
        pull_low = 1'h1;
      end
      if (i == low) begin
        pull_low = 1'h0;
      end
      if (i == 34) begin
        seen = line;
      end
      @(posedge tclk);
    end
  endtask
  task automatic send_start();
    logic s;
    pulse(121, 147, s);
  endtask
  task automatic send_block(input logic [7:0] d, input logic eom,
    output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      pulse(bad != 0 ? bad : (d[i] ? 20 : 49), 79, s);
      bad = 0;
    end
    pulse(eom ? 20 : 49, 79, s);
    pulse(20, 79, ack);
  endtask
endmodule
`default_nettype wire

// *** sim/tb.sv ***
// Self-checking bench for the line receiver.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  error_cnt++; $display("CHECK FAILED %s expected %h seen %h", n, e, g); \
  end end
module tb import clr_pkg::*;;
  logic clk = 1'h0, rst_n = 1'h0, hsel = 1'h0, hwrite = 1'h0;
  logic tclk = 1'h0, ah, ad, line, pull_low;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [31:0] lf = 32'hafdade29;
  logic [1:0] htrans = 2'h0;
  logic hreadyout, hresp, cec_out, cec_oe, irq_start, irq_rx, irq_err;
  int error_cnt = 0, cmp_count = 0, n_rx = 0, n_st = 0, n_er = 0;
  logic [9:0] q[$];
  always #20 clk = ~clk;
  // The timer clock is fast so that whole messages fit in a short run.
  initial begin
    #7;
    forever #120 tclk = ~tclk;
  end
  assign line = !(pull_low || (cec_oe && !cec_out));
  clr_line_receiver uut (.clk(clk), .rst_n(rst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .cec_in(line),
    .timer_out_clock(tclk), .cec_out(cec_out), .cec_oe(cec_oe),
    .irq_start(irq_start), .irq_rx(irq_rx), .irq_err(irq_err));
  clr_remote r (.tclk(tclk), .line(line), .pull_low(pull_low));
  // ------------------------------------------
  // Helpers
  // ------------------------------------------
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic [9:0] bufv(input logic [7:0] d,
    input logic e, input logic a);
    return {a, e, d};
  endfunction
  function automatic logic [31:0] rst_val(input int i);
    return i == 2 ? TIME_RST : i == 3 ? START_RST :
      i == 4 ? WAVE_RST : 32'h0;
  endfunction
  task automatic ahb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge clk); while (hreadyout !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'h1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'h1, a, d);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    ahb(1'h0, a, 32'h0);
    `CHK("register", e, rd)
  endtask
  task automatic clr();
    wr(A_STAT, 32'h7f);
    n_rx = 0;
    n_st = 0;
    n_er = 0;
    q.delete();
  endtask
  task automatic msg(input logic [7:0] h, input logic [7:0] d,
    input int nb, input logic eh, input logic ed, input int es,
    input int ee);
    clr();
    r.send_start();
    r.send_block(h, nb == 1, ah);
    if (nb == 2) r.send_block(d, 1'h1, ad);
    repeat (300) @(posedge clk);
    `CHK("ack head", eh, ah)
    `CHK("start irq", es, n_st)
    `CHK("error irq", ee, n_er)
    if (nb == 2) `CHK("ack data", ed, ad)
    if (ee == 0) begin
      `CHK("rx irq", nb, n_rx)
      `CHK("buf head", bufv(h, nb == 1, eh), q[0])
      if (nb == 2) `CHK("buf data", bufv(d, 1'h1, ed), q[1])
    end
  endtask
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(negedge clk) begin
    if (irq_rx === 1'h1) n_rx++;
    if (irq_start === 1'h1) n_st++;
    if (irq_err === 1'h1) n_er++;
  end
  // Each stored block is read at once, so no overrun builds up.
  always @(negedge clk) if (irq_rx === 1'h1) begin
    ahb(1'h0, A_BUF, 32'h0);
    q.push_back(rd[9:0]);
  end
  initial begin
    repeat (95000) @(posedge clk);
    error_cnt++;
    end_sim();
  end
  // ------------------------------------------
  // Scenarios
  // ------------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'h1;
    for (int i = 0; i < 8; i++) rchk(8'(i * 4), rst_val(i));
    lf = nxt(lf);
    wr(A_ADDR, lf);
    rchk(A_ADDR, {16'h0, lf[15:0]});
    wr(8'h1c, lf);
    rchk(8'h1c, 32'h0);
    wr(A_CTRL, 32'hff);
    rchk(A_CTRL, 32'h7f);
    wr(A_TIME, 32'hc800000e);
    $display("test registers done");
    lf = nxt(lf);
    wr(A_ADDR, {16'h0, lf[15:0] & 16'h7fdf | 16'h0010});
    wr(A_CTRL, 32'h07);
    msg(8'h34, lf[23:16], 2, 1'h0, 1'h0, 1, 0);
    ahb(1'h0, A_STAT, 32'h0);
    `CHK("stat end start", 2'h3, rd[1:0])
    wr(A_CTRL, 32'h0b);
    msg(8'h34, lf[31:24], 2, 1'h0, 1'h1, 0, 0);
    wr(A_CTRL, 32'h13);
    msg(8'h35, lf[7:0], 2, 1'h1, 1'h1, 0, 0);
    wr(A_CTRL, 32'h03);
    for (int m = 0; m < 2; m++) begin
      wr(A_ADDR, {16'h0, m[0], 15'h0010});
      msg(8'h3f, 8'h0, 1, !m[0], 1'h1, 0, 0);
    end
    $display("test acknowledge done");
    clr();
    r.send_start();
    r.pulse(20, 50, ah);
    r.pulse(20, 79, ah);
    repeat (1200) @(posedge clk);
    ahb(1'h0, A_STAT, 32'h0);
    `CHK("stat min", 1'h1, rd[3])
    `CHK("min err irq", 1, n_er)
    `CHK("min rx irq", 0, n_rx)
    clr();
    r.send_start();
    r.send_block(8'h34, 1'h0, ah);
    r.send_start();
    r.send_block(8'h34, 1'h1, ad);
    repeat (300) @(posedge clk);
    ahb(1'h0, A_STAT, 32'h0);
    `CHK("stat max", 1'h1, rd[2])
    `CHK("restart err", 1, n_er)
    `CHK("restart rx", 2, n_rx)
    `CHK("restart buf", bufv(8'h34, 1'h1, 1'h0), q[1])
    $display("test cycle errors done");
    clr();
    fork
      begin
        r.send_start();
        r.send_block(8'h34, 1'h1, ah);
      end
      begin
        repeat (3000) @(posedge clk);
        wr(A_CTRL, 32'h02);
      end
    join
    `CHK("off ack", 1'h1, ah)
    `CHK("off rx", 0, n_rx)
    wr(A_CTRL, 32'h63);
    r.bad = 30;
    msg(8'hb4, 8'h0, 1, 1'h1, 1'h1, 0, 1);
    ahb(1'h0, A_STAT, 32'h0);
    `CHK("stat wave", 1'h1, rd[6])
    clr();
    r.send_start();
    r.pulse(30, 79, ah);
    repeat (1800) @(posedge clk);
    ahb(1'h0, A_STAT, 32'h0);
    `CHK("stat tout", 2'h3, {rd[6], rd[2]})
    `CHK("tout err irq", 1, n_er)
    `CHK("tout rx irq", 0, n_rx)
    $display("test disable and suspend done");
    end_sim();
  end
endmodule
`default_nettype wire
